// ==== hw/pulse_out.sv ====
// Contract
// R1: In rate mode a continuous pulse train of the set width and period leaves the output while the gate is at its active level.
// R2: In rate mode the pulse train stops at once when the gate leaves its active level.
// R3: Output frequencies up to 20 MHz are supported and the period never falls below that limit.
// R4: The period is counted in ticks of either the divided internal clock or the external clock.
// R5: Rate mode takes polarity, width, divider and an active-low or active-high level gate from software.
// R6: In one-shot mode exactly one pulse follows the selected gate edge.
// R7: After the one-shot pulse the channel halts and ignores all further clock and gate activity.
// R8: One-shot mode takes polarity and divider from software.
// R9: Both one-shot modes hold the output active for the whole period, whatever width is set.
// R10: Repetitive one-shot mode emits a pulse on every selected gate edge until software stops it.
// R11: Gate edges that arrive during a repetitive pulse are ignored.
// R12: Software should pick the internal divided clock for the one-shot modes.
// R13: A software run bit arms or stops the channel, and stopping returns the output to idle.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "pulse_out_params.svh"
module pulse_out (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // AXI4-Lite write address channel.
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Channel pins.
    input wire logic GATE_IN,
    input wire logic EXT_CLK_IN,
    output logic PULSE_OUT
);

    // Register contents.
    pulse_out_pkg::ctrl_t ctrl;
    logic [31:0] div;
    logic [31:0] period;
    logic [31:0] width;

    // Bus holding state.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // Channel state.
    pulse_out_pkg::state_t state;
    pulse_out_pkg::state_t next_state;
    pulse_out_pkg::pin_t gate;
    pulse_out_pkg::pin_t ext;
    logic int_tick;
    logic tick;
    logic [31:0] phase;
    logic [31:0] last_phase;
    logic phase_end;
    logic [7:0] cyc;
    logic cyc_ok;
    logic gate_act;
    logic gate_edge;
    logic period_done;
    logic active;
    logic is_rate;

    // Unused protection bits.
    logic prot_unused;
    assign prot_unused = ^{S_AXI_AWPROT, S_AXI_ARPROT};

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Pin synchronisers for the gate and the external clock.
    pin_sync gate_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .pin(GATE_IN),
        .sync(gate)
    );

    pin_sync ext_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .pin(EXT_CLK_IN),
        .sync(ext)
    );

    // Internal clock divider, running only while the run bit is set and the internal clock is selected.
    tick_divider int_div (
        .clk(CLK),
        .rst_b(RST_B),
        .enable(ctrl.run && !ctrl.ext_clk),
        .div(div),
        .tick(int_tick)
    );

    // R4: clock source select
    assign tick = ctrl.ext_clk ? ext.rise : int_tick;

    // Write address and data are taken in either order, one write at a time.
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign do_write = aw_held && w_held && !S_AXI_BVALID;

    // Hold the write address until its data is also present.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Hold the write data until its address is also present.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response, with an error for an address that maps nothing writable.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr)
                `REG_CTRL, `REG_DIV, `REG_PERIOD, `REG_WIDTH: S_AXI_BRESP <= `RESP_OKAY;
                default: S_AXI_BRESP <= `RESP_SLVERR;
            endcase
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // R5: software configuration
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl <= '0;
            div <= `DIV_RST;
            period <= `PERIOD_RST;
            width <= `WIDTH_RST;
        end else if (do_write) begin
            case (aw_addr)
                `REG_CTRL: begin
                    if (w_strb[0]) begin
                        ctrl <= pulse_out_pkg::ctrl_t'(w_data[5:0]);
                    end
                end
                `REG_DIV: div <= merge(div, w_data, w_strb);
                `REG_PERIOD: period <= merge(period, w_data, w_strb);
                `REG_WIDTH: width <= merge(width, w_data, w_strb);
                default: ;
            endcase
        end
    end

    // Reads answer one cycle after the address is taken.
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // Read data mux, zero with an error for an unmapped address.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RESP_OKAY;
            case (S_AXI_ARADDR)
                `REG_CTRL: S_AXI_RDATA <= {26'h0, ctrl};
                `REG_DIV: S_AXI_RDATA <= div;
                `REG_PERIOD: S_AXI_RDATA <= period;
                `REG_WIDTH: S_AXI_RDATA <= width;
                `REG_STATUS: begin
                    S_AXI_RDATA <= {27'h0, gate.level, PULSE_OUT,
                                    state == pulse_out_pkg::ST_DONE,
                                    state == pulse_out_pkg::ST_PULSE,
                                    state != pulse_out_pkg::ST_IDLE};
                end
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= `RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Gate qualification for level and edge modes.
    assign is_rate = ctrl.mode == pulse_out_pkg::MODE_RATE;
    assign gate_act = gate.level == ctrl.gate_hi;
    assign gate_edge = ctrl.gate_hi ? gate.rise : gate.fall;

    // The last tick of a period; a period of zero behaves as one.
    assign last_phase = (period == 32'h0000_0000) ? 32'h0000_0000 : period - 32'h0000_0001;

    // R3: rate limit
    assign cyc_ok = cyc >= 8'(`MIN_OUT_CYCLES - 1);
    assign period_done = (phase_end || (tick && phase >= last_phase)) && cyc_ok;

    // Next channel state.
    always_comb begin
        next_state = state;
        unique case (state)
            pulse_out_pkg::ST_IDLE: begin
                if (ctrl.run) begin
                    next_state = pulse_out_pkg::ST_ARMED;
                end
            end
            pulse_out_pkg::ST_ARMED: begin
                // R1: gate enables train
                if (is_rate && gate_act) begin
                    next_state = pulse_out_pkg::ST_PULSE;
                // R6: edge triggers pulse
                end else if (!is_rate && gate_edge) begin
                    next_state = pulse_out_pkg::ST_PULSE;
                end
            end
            pulse_out_pkg::ST_PULSE: begin
                // R2: gate stops train
                if (is_rate && !gate_act) begin
                    next_state = pulse_out_pkg::ST_ARMED;
                end else if (!is_rate && period_done) begin
                    // R10: re-arm after pulse
                    if (ctrl.mode == pulse_out_pkg::MODE_REPEAT) begin
                        next_state = pulse_out_pkg::ST_ARMED;
                    end else begin
                        next_state = pulse_out_pkg::ST_DONE;
                    end
                end
            end
            // R7: halt after one-shot
            pulse_out_pkg::ST_DONE: next_state = pulse_out_pkg::ST_DONE;
        endcase
        // R13: stop returns to idle
        if (!ctrl.run) begin
            next_state = pulse_out_pkg::ST_IDLE;
        end
    end

    // State register.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= pulse_out_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // R4: period counted in ticks
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase <= 32'h0000_0000;
            phase_end <= 1'b0;
        end else if (state != pulse_out_pkg::ST_PULSE || period_done) begin
            phase <= 32'h0000_0000;
            phase_end <= 1'b0;
        end else if (tick) begin
            if (phase >= last_phase) begin
                phase_end <= 1'b1; // Waits here for the rate limit.
            end else begin
                phase <= phase + 32'h0000_0001;
            end
        end
    end

    // Clock cycles since the period began, saturating.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cyc <= 8'h00;
        end else if (state != pulse_out_pkg::ST_PULSE || period_done) begin
            cyc <= 8'h00;
        end else if (!cyc_ok) begin
            cyc <= cyc + 8'h01;
        end
    end

    // R11: edges ignored while pulsing
    // R9: full duty for one-shots
    assign active = (state == pulse_out_pkg::ST_PULSE) && (!is_rate || phase < width);

    // R8: polarity applied
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PULSE_OUT <= 1'b0;
        end else begin
            PULSE_OUT <= active ^ ctrl.pol;
        end
    end

endmodule : pulse_out

// ==== hw/pulse_out_params.svh ====
`ifndef PULSE_OUT_PARAMS_SVH
`define PULSE_OUT_PARAMS_SVH

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_DIV 8'h04
`define REG_PERIOD 8'h08
`define REG_WIDTH 8'h0C
`define REG_STATUS 8'h10

// Control field positions.
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_EXT_CLK 3
`define CTRL_POL 4
`define CTRL_GATE_HI 5

// Reset values.
`define DIV_RST 32'h0000_0001
`define PERIOD_RST 32'h0000_0002
`define WIDTH_RST 32'h0000_0001

// Clock rate and highest output frequency, in MHz.
`define CLK_FREQ_MHZ 250
`define OUT_FREQ_MAX_MHZ 20
// Least output period in clock cycles, rounded up.
`define MIN_OUT_CYCLES ((`CLK_FREQ_MHZ + `OUT_FREQ_MAX_MHZ - 1) / `OUT_FREQ_MAX_MHZ)

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/pulse_out_pkg.sv ====
package pulse_out_pkg;

    // Pulse output modes.
    typedef enum logic [1:0] {
        MODE_RATE = 2'h0,
        MODE_ONESHOT = 2'h1,
        MODE_REPEAT = 2'h2
    } mode_t;

    // Channel sequencing states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARMED = 2'h1,
        ST_PULSE = 2'h2,
        ST_DONE = 2'h3
    } state_t;

    // Control register contents.
    typedef struct packed {
        logic gate_hi;
        logic pol;
        logic ext_clk;
        logic [1:0] mode;
        logic run;
    } ctrl_t;

    // Synchronised pin with its edges.
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } pin_t;

endpackage : pulse_out_pkg

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Raw pin.
    input wire logic pin,
    // Synchronised level and edge pulses.
    output pulse_out_pkg::pin_t sync
);

    logic meta;
    logic stable;
    logic prev;

    // Two flip-flops take the pin into the clock domain, a third holds the last level.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
            prev <= stable;
        end
    end

    // Edges are seen only between the second and third stages.
    assign sync.level = stable;
    assign sync.rise = stable & ~prev;
    assign sync.fall = ~stable & prev;

endmodule : pin_sync

// ==== hw/tick_divider.sv ====
`timescale 1ns/1ps
module tick_divider (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Enable and division ratio.
    input wire logic enable,
    input wire logic [31:0] div,
    // One-cycle enable pulse at the divided rate.
    output logic tick
);

    logic [31:0] count;
    logic [31:0] last;

    // A ratio of zero behaves as one.
    assign last = (div == 32'h0000_0000) ? 32'h0000_0000 : div - 32'h0000_0001;
    assign tick = enable && (count >= last);

    // The count restarts whenever the divider is disabled.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0000_0000;
        end else if (!enable || tick) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

endmodule : tick_divider

// ==== test/pulse_out_chk.sv ====
`timescale 1ns/1ps
module pulse_out_chk (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Channel pins.
    input wire logic GATE_IN,
    input wire logic PULSE_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    pulse_out_pkg::ctrl_t ctrl;
    logic wr, act, off;
    logic [4:0] gap;
    logic [1:0] shots;
    logic pol_d1, pol_d2;
    logic [2:0] wr_sh;
    // Accepted write, active output level and the gated-off rate condition.
    assign wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    assign act = PULSE_OUT ^ pol_d2;
    assign off = ctrl.run && ctrl.mode == 2'h0 && GATE_IN != ctrl.gate_hi;
    // Shadow of the control word as it is written.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) ctrl <= '0;
        else if (wr && S_AXI_AWADDR == 8'h00) ctrl <= S_AXI_WDATA[5:0];
    end
    // The output shows a new polarity two cycles after the write and may glitch until then.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pol_d1 <= 1'b0;
            pol_d2 <= 1'b0;
            wr_sh <= 3'h0;
        end else begin
            pol_d1 <= ctrl.pol;
            pol_d2 <= pol_d1;
            wr_sh <= {wr_sh[1:0], wr};
        end
    end
    // Cycles since the output turned active; a write forgets the history.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) gap <= 5'h1F;
        else if (wr || wr_sh != 3'h0) gap <= 5'h1F;
        else if ($rose(act)) gap <= 5'h0;
        else if (gap != 5'h1F) gap <= gap + 5'h1;
    end
    // Pulses begun since a one-shot run was armed.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) shots <= 2'h0;
        else if (!ctrl.run) shots <= 2'h0;
        else if (ctrl.mode == 2'h1 && $rose(act) && shots != 2'h3) shots <= shots + 2'h1;
    end
    sequence rate_gone;
        off [*6];
    endsequence
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("read data dropped early");
    chk_read_answer: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
        else $error("read not answered");
    chk_write_answer: assert property (wr |-> ##[1:2] S_AXI_BVALID)
        else $error("write not answered");
    chk_gate_stop: assert property (rate_gone |-> !act)
        else $error("pulses continue without gate");
    chk_min_period: assert property ($rose(act) |-> gap >= 5'hC)
        else $error("output period below limit");
    chk_single_shot: assert property (ctrl.mode == 2'h1 |-> shots <= 2'h1)
        else $error("second one-shot pulse");
    chk_shot_width: assert property ($rose(act) && ctrl.run && ctrl.mode != 2'h0 |=> act [*8])
        else $error("one-shot pulse too short");
    chk_stop_idle: assert property ((!ctrl.run && $stable(ctrl)) [*4] |-> !act)
        else $error("output active while stopped");
endmodule : pulse_out_chk

bind pulse_out pulse_out_chk u_chk (.CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_RVALID, .S_AXI_RREADY, .GATE_IN, .PULSE_OUT);

// ==== test/pace_model.sv ====
`timescale 1ns/1ps
module pace_model (
    // Clock and bench commands.
    input wire logic clk,
    input wire logic gate_lvl,
    input wire logic ext_on,
    // Output of the channel.
    input wire logic pulse,
    // Pins towards the channel and the paced event count.
    output logic gate,
    output logic ext_clk,
    output logic [15:0] edges
);
    logic [2:0] phase = 3'h0;
    logic last = 1'b0;
    // The gate source drives its level straight onto the pin.
    assign gate = gate_lvl;
    // The count clock stands low unless enabled, then has a six-cycle period.
    assign ext_clk = phase >= 3'h3;
    always @(posedge clk) begin
        if (!ext_on || phase == 3'h5) phase <= 3'h0;
        else phase <= phase + 3'h1;
    end
    // The paced logic counts every rising edge of the output.
    initial edges = 16'h0;
    always @(posedge clk) begin
        last <= pulse;
        if (pulse && !last) edges <= edges + 16'h1;
    end
endmodule : pace_model

// ==== test/test_counter_pulse_output_modes.sv ====
`timescale 1ns/1ps
`include "pulse_out_params.svh"
module test_counter_pulse_output_modes;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] wr;
        logic [31:0] rd;
        logic [1:0] rr;
    } row_t;
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, gate_lvl, ext_on;
    logic awready, wready, bvalid, arready, rvalid, gate, ext_clk, pulse, pol;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] edges, e0;
    int h, l, mismatches, comparisons;
    row_t rows [6];

    pulse_out DUT (
        .CLK(clk), .RST_B(rst_b),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .GATE_IN(gate), .EXT_CLK_IN(ext_clk), .PULSE_OUT(pulse)
    );
    pace_model u_pace (.clk(clk), .gate_lvl(gate_lvl), .ext_on(ext_on), .pulse(pulse),
        .gate(gate), .ext_clk(ext_clk), .edges(edges));

    // The 250 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end

    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // One register write; address and data are released as each is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        int n;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        s = bresp;
        bready <= 1'b0;
        if (!bvalid) begin
            mismatches++;
            close_out();
        end
        @(posedge clk);
    endtask : axi_wr

    // One register read.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        v = rdata;
        s = rresp;
        rready <= 1'b0;
        if (!rvalid) begin
            mismatches++;
            close_out();
        end
        @(posedge clk);
    endtask : axi_rd

    // Divider, period, width and control in that order.
    task automatic cfg(input logic [31:0] dv, input logic [31:0] pr, input logic [31:0] wd,
                       input logic [31:0] ct);
        axi_wr(`REG_DIV, dv, r);
        axi_wr(`REG_PERIOD, pr, r);
        axi_wr(`REG_WIDTH, wd, r);
        axi_wr(`REG_CTRL, ct, r);
        pol = ct[4];
    endtask : cfg

    // Waits, bounded, until the output's active state equals v.
    task automatic wt(input logic v, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((pulse ^ pol) !== v && c < 2000);
        if ((pulse ^ pol) !== v) begin
            mismatches++;
            close_out();
        end
    endtask : wt

    // Active and idle lengths of the second full period, as the tick phase may cut the first.
    task automatic meas();
        int c;
        wt(1'b1, c);
        wt(1'b0, c);
        wt(1'b1, c);
        wt(1'b0, h);
        wt(1'b1, l);
    endtask : meas

    // Main sequence.
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, gate_lvl, ext_on, pol} = '0;
        {awaddr, araddr, wdata, mismatches, comparisons} = '0;
        rows = '{'{`REG_DIV, 32'h3, `RESP_OKAY, 32'h3, `RESP_OKAY},
                 '{`REG_PERIOD, 32'h14, `RESP_OKAY, 32'h14, `RESP_OKAY},
                 '{`REG_WIDTH, 32'h7, `RESP_OKAY, 32'h7, `RESP_OKAY},
                 '{`REG_STATUS, 32'hFF, `RESP_SLVERR, 32'h0, `RESP_OKAY},
                 '{8'h14, 32'h5, `RESP_SLVERR, 32'h0, `RESP_SLVERR},
                 '{`REG_CTRL, 32'h10, `RESP_OKAY, 32'h10, `RESP_OKAY}};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].d, r);
            check("bresp", r, rows[i].wr);
            axi_rd(rows[i].a, d, r);
            check("rdata", d, rows[i].rd);
            check("rresp", r, rows[i].rr);
        end
        repeat (6) @(posedge clk);
        check("stopped idle", pulse, 1'b1);
        $display("Done: registers");
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        pol = 1'b0;
        check("reset out", pulse, 1'b0);
        axi_rd(`REG_DIV, d, r);
        check("div reset", d, `DIV_RST);
        axi_rd(`REG_PERIOD, d, r);
        check("period reset", d, `PERIOD_RST);
        axi_rd(`REG_WIDTH, d, r);
        check("width reset", d, `WIDTH_RST);
        $display("Done: reset");
        cfg(32'h1, 32'h14, 32'h5, 32'h21);
        gate_lvl <= 1'b1;
        meas();
        check("rate width", h, 5);
        check("rate period", h + l, 20);
        gate_lvl <= 1'b0;
        repeat (8) @(posedge clk);
        e0 = edges;
        check("gate off", pulse, 1'b0);
        repeat (40) @(posedge clk);
        check("no pulses", edges, e0);
        cfg(32'h1, 32'h2, 32'h1, 32'h21);
        gate_lvl <= 1'b1;
        meas();
        check("least period", h + l, `MIN_OUT_CYCLES);
        cfg(32'h1, 32'h14, 32'h5, 32'h11);
        gate_lvl <= 1'b0;
        meas();
        check("low pulse", h, 5);
        axi_wr(`REG_CTRL, 32'h10, r);
        repeat (6) @(posedge clk);
        check("stop idle", pulse, 1'b1);
        $display("Done: rate");
        cfg(32'h2, 32'hA, 32'h5, 32'h21);
        gate_lvl <= 1'b1;
        meas();
        check("divided period", h + l, 20);
        ext_on <= 1'b1;
        cfg(32'h1, 32'h14, 32'h5, 32'h29);
        meas();
        check("external period", h + l, 120);
        ext_on <= 1'b0;
        $display("Done: clock sources");
        for (int g = 1; g >= 0; g--) begin
            axi_wr(`REG_CTRL, 32'h0, r);
            gate_lvl <= !g;
            repeat (5) @(posedge clk);
            cfg(32'h1, 32'h14, 32'h3, g ? 32'h23 : 32'h13);
            // Let a polarity change reach the paced count before it is taken.
            repeat (2) @(posedge clk);
            e0 = edges;
            gate_lvl <= g;
            wt(1'b1, l);
            check("shot start", l < 20, 1'b1);
            wt(1'b0, h);
            check("shot width", h, 20);
            repeat (3) begin
                gate_lvl <= !g;
                repeat (10) @(posedge clk);
                gate_lvl <= g;
                repeat (10) @(posedge clk);
            end
            check("shot idle", pulse, !g);
            check("one shot", edges - e0, 1);
        end
        $display("Done: one-shot");
        axi_wr(`REG_CTRL, 32'h0, r);
        gate_lvl <= 1'b0;
        cfg(32'h1, 32'h14, 32'h3, 32'h25);
        e0 = edges;
        gate_lvl <= 1'b1;
        wt(1'b1, l);
        gate_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        gate_lvl <= 1'b1;
        wt(1'b0, h);
        check("pulse kept", h, 16);
        repeat (40) @(posedge clk);
        check("edge in pulse", edges - e0, 1);
        gate_lvl <= 1'b0;
        repeat (5) @(posedge clk);
        gate_lvl <= 1'b1;
        repeat (40) @(posedge clk);
        check("retrigger", edges - e0, 2);
        $display("Done: repetitive");
        close_out();
    end
endmodule : test_counter_pulse_output_modes
